//--- rsslc_pkg.sv
package rsslc_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_SWITCH_MODE   = 8'h00;
	localparam logic [7:0] OFS_RAMP_STATUS   = 8'h04;
	localparam logic [7:0] OFS_POS_CAPTURE   = 8'h08;
	localparam logic [7:0] OFS_WAIT_TIME     = 8'h0c;
	localparam logic [7:0] OFS_INT_STATUS    = 8'h10;
	localparam logic [7:0] OFS_INT_MASK      = 8'h14;
	localparam logic [7:0] OFS_STALL_CTRL    = 8'h18;

	// ==========================================================
	// Switch mode field positions
	localparam int BIT_STOP_L_EN    = 0;
	localparam int BIT_STOP_R_EN    = 1;
	localparam int BIT_POL_L        = 2;
	localparam int BIT_POL_R        = 3;
	localparam int BIT_EXCHANGE     = 4;
	localparam int BIT_LATCH_L_ACT  = 5;
	localparam int BIT_LATCH_L_INA  = 6;
	localparam int BIT_LATCH_R_ACT  = 7;
	localparam int BIT_LATCH_R_INA  = 8;
	localparam int MODE_W           = 12;

	// ==========================================================
	// Ramp status field positions
	localparam int BIT_LEFT_ACTIVE  = 0;
	localparam int BIT_RIGHT_ACTIVE = 1;
	localparam int BIT_ZERO_WAIT    = 11;
	localparam int BIT_REVERSAL     = 12;
	localparam int BIT_STALL_LIVE   = 13;

	// ==========================================================
	// Interrupt event positions
	localparam int IRQ_CAPTURE      = 0;
	localparam int IRQ_STOP_L       = 1;
	localparam int IRQ_STOP_R       = 2;
	localparam int IRQ_REVERSAL     = 3;
	localparam int IRQ_W            = 4;

	// ==========================================================
	// Reset values and bus answers
	localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
	localparam logic [15:0]       WAIT_RESET = 16'h0000;
	localparam logic [1:0]        RESP_OKAY  = 2'h0;
	localparam logic [1:0]        RESP_SLVERR = 2'h2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [31:0] position;
		logic        moving_pos;
		logic        moving_neg;
		logic        stall_in;
		logic        reversal_in;
	} rsslc_motion_t;

	typedef struct packed {
		logic right;
		logic left;
	} rsslc_pair_t;

	typedef struct packed {
		rsslc_pair_t       sync1;
		rsslc_pair_t       sync2;
		rsslc_pair_t       act_q;
		logic [MODE_W-1:0] mode;
		logic [31:0]       capture;
		logic [15:0]       wait_time;
		logic [15:0]       wait_cnt;
		logic              wait_active;
		logic              stop_q;
		logic              halt;
		logic              reversal;
		logic              stall_en;
		logic              stall_live;
		logic [IRQ_W-1:0]  int_stat;
		logic [IRQ_W-1:0]  int_mask;
		logic              irq;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} rsslc_state_t;

endpackage

//--- rsslc_ctrl.sv
`timescale 1ns/100ps
module rsslc_ctrl #(
	parameter int WAIT_W = 16
) (
	// Clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  RESET_N,
	// AXI4-Lite write address
	input  wire logic [7:0]            S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	// AXI4-Lite read address
	input  wire logic [7:0]            S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	// Ramp generator side
	input  wire rsslc_pkg::rsslc_motion_t MOTION,
	output logic                       MOTOR_HALT,
	output logic                       IRQ,
	// Reference switch pins
	input  wire logic                  LEFT_SWITCH_INPUT,
	input  wire logic                  RIGHT_SWITCH_INPUT
);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		return addr == rsslc_pkg::OFS_SWITCH_MODE || addr == rsslc_pkg::OFS_RAMP_STATUS ||
			addr == rsslc_pkg::OFS_POS_CAPTURE || addr == rsslc_pkg::OFS_WAIT_TIME ||
			addr == rsslc_pkg::OFS_INT_STATUS || addr == rsslc_pkg::OFS_INT_MASK ||
			addr == rsslc_pkg::OFS_STALL_CTRL;
	endfunction

	// ==========================================================
	// State
	localparam int IRQ_EV_W = rsslc_pkg::IRQ_W;

	rsslc_pkg::rsslc_state_t s;
	rsslc_pkg::rsslc_state_t next_s;

	rsslc_pkg::rsslc_pair_t  side;
	rsslc_pkg::rsslc_pair_t  act;
	logic                    stop_l;
	logic                    stop_r;
	logic                    stop_now;
	logic                    cap_hit;
	logic [IRQ_EV_W-1:0]     events;
	logic [31:0]             wmerged;
	logic                    read_status;

	always_comb begin
		next_s = s;
		// Synchroniser, first stage feeds second only
		next_s.sync1.left  = LEFT_SWITCH_INPUT;
		next_s.sync1.right = RIGHT_SWITCH_INPUT;
		next_s.sync2       = s.sync1;

		// Side exchange before polarity
		side.left  = s.mode[rsslc_pkg::BIT_EXCHANGE] ? s.sync2.right : s.sync2.left;
		side.right = s.mode[rsslc_pkg::BIT_EXCHANGE] ? s.sync2.left : s.sync2.right;
		// Polarity 0 high active, 1 low active
		act.left   = side.left ^ s.mode[rsslc_pkg::BIT_POL_L];
		act.right  = side.right ^ s.mode[rsslc_pkg::BIT_POL_R];
		next_s.act_q = act;

		// Capture on selected logical edges
		cap_hit = (s.mode[rsslc_pkg::BIT_LATCH_R_INA] && s.act_q.right && !act.right)
			|| (s.mode[rsslc_pkg::BIT_LATCH_R_ACT] && !s.act_q.right && act.right)
			|| (s.mode[rsslc_pkg::BIT_LATCH_L_INA] && s.act_q.left && !act.left)
			|| (s.mode[rsslc_pkg::BIT_LATCH_L_ACT] && !s.act_q.left && act.left);
		if (cap_hit) begin
			next_s.capture = MOTION.position;
		end

		// Stop only when moving toward the active switch
		stop_l   = s.mode[rsslc_pkg::BIT_STOP_L_EN] && act.left && MOTION.moving_neg;
		stop_r   = s.mode[rsslc_pkg::BIT_STOP_R_EN] && act.right && MOTION.moving_pos;
		stop_now = stop_l || stop_r;
		next_s.stop_q = stop_now;

		// Standstill wait after the switch releases
		if (stop_now) begin
			next_s.wait_active = 1'b0;
			next_s.wait_cnt    = 16'h0000;
		end else if (s.stop_q && s.wait_time != 16'h0000) begin
			next_s.wait_active = 1'b1;
			next_s.wait_cnt    = s.wait_time;
		end else if (s.wait_active) begin
			next_s.wait_cnt    = s.wait_cnt - 16'h0001;
			next_s.wait_active = s.wait_cnt > 16'h0001;
		end
		// Resume once released and wait done
		next_s.halt = stop_now || next_s.wait_active;

		// Live stall indication
		next_s.stall_live = MOTION.stall_in && s.stall_en;

		// Event sources
		events = '0;
		events[rsslc_pkg::IRQ_CAPTURE]  = cap_hit;
		events[rsslc_pkg::IRQ_STOP_L]   = stop_l && !(s.stop_q && s.act_q.left);
		events[rsslc_pkg::IRQ_STOP_R]   = stop_r && !(s.stop_q && s.act_q.right);
		events[rsslc_pkg::IRQ_REVERSAL] = MOTION.reversal_in;

		// ======================================================
		// Write channel
		if (S_AXI_AWVALID && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = S_AXI_WDATA;
			next_s.wstrb = S_AXI_WSTRB;
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end
		wmerged = 32'h0000_0000;
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = mapped(s.awaddr) ? rsslc_pkg::RESP_OKAY : rsslc_pkg::RESP_SLVERR;
			case (s.awaddr)
				rsslc_pkg::OFS_SWITCH_MODE: begin
					wmerged     = merge({20'h00000, s.mode}, s.wdata, s.wstrb);
					next_s.mode = wmerged[rsslc_pkg::MODE_W-1:0];
				end
				rsslc_pkg::OFS_WAIT_TIME: begin
					wmerged          = merge({16'h0000, s.wait_time}, s.wdata, s.wstrb);
					next_s.wait_time = wmerged[15:0];
				end
				rsslc_pkg::OFS_INT_STATUS: begin
					if (s.wstrb[0]) begin
						next_s.int_stat = s.int_stat & ~s.wdata[IRQ_EV_W-1:0];
					end
				end
				rsslc_pkg::OFS_INT_MASK: begin
					if (s.wstrb[0]) begin
						next_s.int_mask = s.wdata[IRQ_EV_W-1:0];
					end
				end
				rsslc_pkg::OFS_STALL_CTRL: begin
					if (s.wstrb[0]) begin
						next_s.stall_en = s.wdata[0];
					end
				end
				default: begin
					wmerged = 32'h0000_0000;
				end
			endcase
		end
		// Set wins over clear
		next_s.int_stat = next_s.int_stat | events;

		// ======================================================
		// Read channel
		read_status = 1'b0;
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = mapped(S_AXI_ARADDR) ? rsslc_pkg::RESP_OKAY : rsslc_pkg::RESP_SLVERR;
			next_s.rdata  = 32'h0000_0000;
			case (S_AXI_ARADDR)
				rsslc_pkg::OFS_SWITCH_MODE: begin
					next_s.rdata[rsslc_pkg::MODE_W-1:0] = s.mode;
				end
				rsslc_pkg::OFS_RAMP_STATUS: begin
					read_status = 1'b1;
					next_s.rdata[rsslc_pkg::BIT_LEFT_ACTIVE]  = s.act_q.left;
					next_s.rdata[rsslc_pkg::BIT_RIGHT_ACTIVE] = s.act_q.right;
					next_s.rdata[rsslc_pkg::BIT_ZERO_WAIT]    = s.wait_active;
					next_s.rdata[rsslc_pkg::BIT_REVERSAL]     = s.reversal;
					next_s.rdata[rsslc_pkg::BIT_STALL_LIVE]   = s.stall_live;
				end
				rsslc_pkg::OFS_POS_CAPTURE: begin
					next_s.rdata = s.capture;
				end
				rsslc_pkg::OFS_WAIT_TIME: begin
					next_s.rdata[15:0] = s.wait_time;
				end
				rsslc_pkg::OFS_INT_STATUS: begin
					next_s.rdata[IRQ_EV_W-1:0] = s.int_stat;
				end
				rsslc_pkg::OFS_INT_MASK: begin
					next_s.rdata[IRQ_EV_W-1:0] = s.int_mask;
				end
				rsslc_pkg::OFS_STALL_CTRL: begin
					next_s.rdata[0] = s.stall_en;
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end
		// Reversal flag: clear on status read, new event wins
		next_s.reversal = (s.reversal && !read_status) || MOTION.reversal_in;

		// Ready flags follow channel occupancy
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
		next_s.irq     = |(next_s.int_stat & next_s.int_mask);
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			s           <= '0;
			s.mode      <= rsslc_pkg::MODE_RESET;
			s.wait_time <= rsslc_pkg::WAIT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign S_AXI_AWREADY = s.awready;
	assign S_AXI_WREADY  = s.wready;
	assign S_AXI_BVALID  = s.bvalid;
	assign S_AXI_BRESP   = s.bresp;
	assign S_AXI_ARREADY = s.arready;
	assign S_AXI_RVALID  = s.rvalid;
	assign S_AXI_RDATA   = s.rdata;
	assign S_AXI_RRESP   = s.rresp;
	assign MOTOR_HALT    = s.halt;
	assign IRQ           = s.irq;

endmodule // rsslc_ctrl

//--- rsslc_ctrl_properties.sv
`timescale 1ns/100ps
module rsslc_ctrl_properties (
	// Clock and reset
	input wire logic			CLK_SYS,
	input wire logic			RESET_N,
	// Register bus
	input wire logic [7:0]			S_AXI_AWADDR,
	input wire logic			S_AXI_AWVALID,
	input wire logic			S_AXI_AWREADY,
	input wire logic			S_AXI_WVALID,
	input wire logic			S_AXI_WREADY,
	input wire logic [1:0]			S_AXI_BRESP,
	input wire logic			S_AXI_BVALID,
	input wire logic			S_AXI_BREADY,
	input wire logic [7:0]			S_AXI_ARADDR,
	input wire logic			S_AXI_ARVALID,
	input wire logic			S_AXI_ARREADY,
	input wire logic [31:0]			S_AXI_RDATA,
	input wire logic [1:0]			S_AXI_RRESP,
	input wire logic			S_AXI_RVALID,
	input wire logic			S_AXI_RREADY,
	// Motion side
	input wire rsslc_pkg::rsslc_motion_t	MOTION,
	input wire logic			MOTOR_HALT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// ==========================================================
	// Bus handshakes
	wire w_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	wire r_take = S_AXI_ARVALID && S_AXI_ARREADY;
	property p_b_answer;
		w_take |-> ##2 S_AXI_BVALID;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer missing");
	property p_b_hold;
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_unmapped;
		w_take && S_AXI_AWADDR > 8'h1b |-> ##2 S_AXI_BRESP == 2'h2;
	endproperty
	a_b_unmapped: assert property (p_b_unmapped) else $error("unmapped write not refused");
	property p_r_unmapped;
		r_take && S_AXI_ARADDR > 8'h1b |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
	endproperty
	a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
	property p_r_hold;
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_busy;
		S_AXI_RVALID |-> !S_AXI_ARREADY;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while answer pending");
	property p_aw_busy;
		S_AXI_BVALID |-> !S_AXI_AWREADY;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while answer pending");
	// ==========================================================
	// Switch stop
	property p_halt_motion;
		$rose(MOTOR_HALT) |-> $past(MOTION.moving_pos || MOTION.moving_neg);
	endproperty
	a_halt_motion: assert property (p_halt_motion) else $error("halt while still");
endmodule // rsslc_ctrl_properties

//--- rsslc_switch_model.sv
`timescale 1ns/100ps
module rsslc_switch_model (
	// Clock
	input wire logic	clk,
	// Contact state and wiring level
	input wire logic [1:0]	press,
	input wire logic [1:0]	low_act,
	input wire logic	slow,
	// Pins, bit 0 left
	output logic [1:0]	pin
);
	logic [9:0] dly = 10'h000;
	// Slow contacts settle five cycles late
	always @(posedge clk) begin
		dly <= {dly[7:0], press};
	end
	assign pin = (slow ? dly[9:8] : press) ^ low_act;
endmodule // rsslc_switch_model

//--- rsslc_ctrl_test.sv
`timescale 1ns/100ps
module rsslc_ctrl_test;
	typedef struct packed {
		logic [11:0]	mode;
		logic [1:0]	prs, mv;
		logic		slow, halt;
		logic [1:0]	st;
		logic		cp, cr;
	} rsslc_row_t;
	// Mode, contacts, motion {pos,neg}, slow, halt, sides, capture on press/release
	localparam rsslc_row_t ROWS [12] = '{
		'{12'h001, 2'h1, 2'h1, 1'h0, 1'h1, 2'h1, 1'h0, 1'h0},
		'{12'h001, 2'h1, 2'h2, 1'h1, 1'h0, 2'h1, 1'h0, 1'h0},
		'{12'h002, 2'h2, 2'h2, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0},
		'{12'h002, 2'h2, 2'h1, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0},
		'{12'h00e, 2'h2, 2'h2, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0},
		'{12'h012, 2'h1, 2'h2, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0},
		'{12'h020, 2'h1, 2'h0, 1'h0, 1'h0, 2'h1, 1'h1, 1'h0},
		'{12'h040, 2'h1, 2'h0, 1'h1, 1'h0, 2'h1, 1'h0, 1'h1},
		'{12'h080, 2'h2, 2'h0, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0},
		'{12'h100, 2'h2, 2'h0, 1'h0, 1'h0, 2'h2, 1'h0, 1'h1},
		'{12'h02c, 2'h1, 2'h1, 1'h0, 1'h0, 2'h1, 1'h1, 1'h0},
		'{12'h000, 2'h1, 2'h1, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0}};
	logic				clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic				awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic				awr, wrdy, bv, arr, rv, halt, irq;
	logic [7:0]			awa = 8'h00, ara = 8'h00;
	logic [31:0]			wd = 32'h0, rd_d, p = 32'h0, ec = 32'h0;
	logic [1:0]			br_s, rr_s, rs, pin, press = 2'h0, low = 2'h0;
	rsslc_pkg::rsslc_motion_t	mo = '0;
	rsslc_row_t			rw;
	int				n_mismatch = 0, num_checks = 0;
	rsslc_ctrl dut (.CLK_SYS(clk), .RESET_N(rst_n),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(br_s), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd_d), .S_AXI_RRESP(rr_s), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.MOTION(mo), .MOTOR_HALT(halt), .IRQ(irq),
		.LEFT_SWITCH_INPUT(pin[0]), .RIGHT_SWITCH_INPUT(pin[1]));
	rsslc_switch_model u_sw (.clk(clk), .press(press), .low_act(low), .slow(slow), .pin(pin));
	// ==========================================================
	// Checking and bus tasks
	task automatic test_done;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo(int k);
		if (k >= 40) begin
			n_mismatch++;
			test_done();
		end
	endtask
	task automatic bus_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		int k;
		logic ga, gw;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		ga = 1'b0;
		gw = 1'b0;
		k = 0;
		while (!(ga && gw && bv === 1'b1) && k < 40) begin
			@(posedge clk);
			k++;
			ga = ga | (awr === 1'b1);
			gw = gw | (wrdy === 1'b1);
			awv <= !ga;
			wv <= !gw;
		end
		r = br_s;
		br <= 1'b0;
		tmo(k);
	endtask
	task automatic bus_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		logic ga;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		ga = 1'b0;
		k = 0;
		while (!(ga && rv === 1'b1) && k < 40) begin
			@(posedge clk);
			k++;
			ga = ga | (arr === 1'b1);
			arv <= !ga;
		end
		d = rd_d;
		r = rr_s;
		rr <= 1'b0;
		tmo(k);
	endtask
	task automatic rc(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
		logic [31:0] d;
		logic [1:0] r;
		bus_rd(a, d, r);
		chk(nm, e, d & m);
	endtask
	// ==========================================================
	// Clock and sequence
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rc("mode reset", 8'h00, 32'h0, 32'hfff);
		rc("wait reset", 8'h0c, 32'h0, 32'hffff);
		foreach (ROWS[i]) begin
			rw = ROWS[i];
			bus_wr(8'h00, 32'h0, rs);
			low <= rw.mode[4] ? {rw.mode[2], rw.mode[3]} : rw.mode[3:2];
			slow <= rw.slow;
			p = 32'h8000_0000 | 32'(i);
			mo <= '{p, rw.mv[1], rw.mv[0], 1'b0, 1'b0};
			bus_wr(8'h00, 32'(rw.mode), rs);
			rc("mode", 8'h00, 32'(rw.mode), 32'hfff);
			press <= rw.prs;
			repeat (12) @(posedge clk);
			chk("halt", 32'(rw.halt), 32'(halt));
			rc("sides", 8'h04, 32'(rw.st), 32'h3);
			if (rw.cp)
				ec = p;
			rc("capture", 8'h08, ec, '1);
			p = p + 32'h100;
			mo.position <= p;
			press <= 2'h0;
			repeat (12) @(posedge clk);
			chk("release", 32'h0, 32'(halt));
			if (rw.cr)
				ec = p;
			rc("capture", 8'h08, ec, '1);
		end
		bus_wr(8'h0c, 32'h14, rs);
		bus_wr(8'h00, 32'h1, rs);
		press <= 2'h1;
		repeat (8) @(posedge clk);
		press <= 2'h0;
		repeat (6) @(posedge clk);
		chk("wait halt", 32'h1, 32'(halt));
		rc("wait flag", 8'h04, 32'h800, 32'h800);
		repeat (30) @(posedge clk);
		chk("wait end", 32'h0, 32'(halt));
		rc("wait flag", 8'h04, 32'h0, 32'h800);
		chk("masked", 32'h0, 32'(irq));
		rc("onset", 8'h10, 32'h2, 32'h2);
		bus_wr(8'h14, 32'h2, rs);
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, 32'(irq));
		bus_wr(8'h10, 32'h2, rs);
		repeat (2) @(posedge clk);
		chk("irq clear", 32'h0, 32'(irq));
		mo.reversal_in <= 1'b1;
		@(posedge clk);
		mo.reversal_in <= 1'b0;
		rc("reversal", 8'h04, 32'h1000, 32'h1000);
		rc("reversal", 8'h04, 32'h0, 32'h1000);
		mo.stall_in <= 1'b1;
		bus_wr(8'h18, 32'h1, rs);
		rc("stall", 8'h04, 32'h2000, 32'h2000);
		bus_wr(8'h18, 32'h0, rs);
		rc("stall", 8'h04, 32'h0, 32'h2000);
		bus_wr(8'h08, 32'hffff_ffff, rs);
		rc("capture ro", 8'h08, ec, '1);
		bus_wr(8'h40, 32'h1, rs);
		chk("bresp", 32'h2, 32'(rs));
		bus_rd(8'h40, p, rs);
		chk("rresp", 32'h2, 32'(rs));
		test_done();
	end
endmodule // rsslc_ctrl_test
bind rsslc_ctrl rsslc_ctrl_properties u_props (.CLK_SYS, .RESET_N, .S_AXI_AWADDR,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
	.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MOTION, .MOTOR_HALT);
